// ### design/ppom_pkg.sv
// Package of constants for the port pin override mux.
package ppom_pkg;
    // -------------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------------
    localparam logic [7:0] PPOM_ADDR_MCU_CONTROL = 8'h35;
    localparam logic [7:0] PPOM_ADDR_PORT_OUT = 8'h40;
    localparam logic [7:0] PPOM_ADDR_PORT_DIR = 8'h41;
    localparam logic [7:0] PPOM_ADDR_PORT_PIN = 8'h42;
    localparam logic [7:0] PPOM_ADDR_INT_CTRL = 8'h43;
    localparam logic [7:0] PPOM_ADDR_INT_FLAG = 8'h44;
    localparam logic [7:0] PPOM_ADDR_INT_SENSE = 8'h45;
    // -------------------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------------------
    localparam int PPOM_BIT_PUD = 4;
    localparam logic [7:0] PPOM_MCU_CONTROL_WMASK = 8'h93;
    localparam logic [7:0] PPOM_MCU_CONTROL_RST = 8'h00;
    localparam logic [7:0] PPOM_PORT_RST = 8'h00;
    // Pull-up is on for {dir, out, pud} equal to this pattern.
    localparam logic [2:0] PPOM_PULLUP_PATTERN = 3'b010;
    // -------------------------------------------------------------------------
    // Interrupt sense encodings
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        PPOM_SENSE_LOW = 2'b00,
        PPOM_SENSE_ANY = 2'b01,
        PPOM_SENSE_FALL = 2'b10,
        PPOM_SENSE_RISE = 2'b11
    } ppom_sense_t;
endpackage : ppom_pkg

// ### design/ppom_pin_cell.sv
// One pin of the port: override muxing of pull-up, driver, value and input enable.
`timescale 1ns/10ps
module ppom_pin_cell (
    input wire logic dir_bit_in,
    input wire logic out_value_bit_in,
    input wire logic global_pullup_disable_in,
    input wire logic sleep_clamp_in,
    input wire logic reset_active_in,
    input wire logic ext_int_enabled_in,
    input wire logic pullup_override_en_in,
    input wire logic pullup_override_val_in,
    input wire logic dir_override_en_in,
    input wire logic dir_override_val_in,
    input wire logic outval_override_en_in,
    input wire logic outval_override_val_in,
    input wire logic input_en_override_en_in,
    input wire logic input_en_override_val_in,
    input wire logic pad_in,
    output logic pullup_en_out,
    output logic pad_out,
    output logic pad_oe_out,
    output logic schmitt_out
);
    import ppom_pkg::*;
    logic normal_pullup;
    logic input_en;
    logic mcu_input_en;

    assign normal_pullup = ({dir_bit_in, out_value_bit_in, global_pullup_disable_in}
                            == PPOM_PULLUP_PATTERN);
    // Reset forces every pull-up off, whatever software had set up.
    assign pullup_en_out = !reset_active_in &&
                           (pullup_override_en_in ? pullup_override_val_in : normal_pullup);
    assign pad_oe_out = dir_override_en_in ? dir_override_val_in : dir_bit_in;
    assign pad_out = outval_override_en_in ? outval_override_val_in : out_value_bit_in;
    // An enabled external interrupt keeps its pin awake through deep sleep.
    assign mcu_input_en = !sleep_clamp_in || ext_int_enabled_in;
    assign input_en = input_en_override_en_in ? input_en_override_val_in : mcu_input_en;
    assign schmitt_out = pad_in && input_en;
endmodule : ppom_pin_cell

// ### design/ppom_sync2.sv
// Two-flop synchroniser for a bus of levels.
`timescale 1ns/10ps
module ppom_sync2 #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : ppom_sync2

// ### design/ppom_port.sv
// Top of one general-purpose port with per-pin alternate function overrides.
`timescale 1ns/10ps
module ppom_port #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    input wire logic sleep_clamp_in,
    input wire logic [WIDTH-1:0] pullup_override_en_in,
    input wire logic [WIDTH-1:0] pullup_override_val_in,
    input wire logic [WIDTH-1:0] dir_override_en_in,
    input wire logic [WIDTH-1:0] dir_override_val_in,
    input wire logic [WIDTH-1:0] outval_override_en_in,
    input wire logic [WIDTH-1:0] outval_override_val_in,
    input wire logic [WIDTH-1:0] out_toggle_override_en_in,
    input wire logic [WIDTH-1:0] input_en_override_en_in,
    input wire logic [WIDTH-1:0] input_en_override_val_in,
    input wire logic [WIDTH-1:0] pad_in,
    output logic [WIDTH-1:0] pad_out,
    output logic [WIDTH-1:0] pad_oe_out,
    output logic [WIDTH-1:0] pullup_en_out,
    output logic [WIDTH-1:0] alt_digital_in_out,
    output logic [WIDTH-1:0] ext_int_flag_out,
    output logic global_pullup_disable_out
);
    import ppom_pkg::*;

    // -------------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------------
    logic [7:0] mcu_control_reg;
    logic [WIDTH-1:0] out_value_bit_reg;
    logic [WIDTH-1:0] dir_bit_reg;
    logic [WIDTH-1:0] ext_int_en_reg;
    logic [WIDTH-1:0] ext_int_flag_reg;
    logic [2*WIDTH-1:0] int_sense_reg;
    logic [WIDTH-1:0] prev_in_reg;
    logic reset_seen_reg;
    logic [7:0] rdata_next;
    logic [WIDTH-1:0] schmitt;
    logic [WIDTH-1:0] pin_input_bit;
    logic [WIDTH-1:0] edge_hit;
    logic [WIDTH-1:0] port_write_strobe_pin;
    logic port_write_strobe;
    logic global_pullup_disable;

    function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] target, input logic we);
        wr_hit = we && (addr == target);
    endfunction : wr_hit

    function automatic logic [7:0] zext(input logic [WIDTH-1:0] v);
        logic [7:0] r;
        r = '0;
        r[WIDTH-1:0] = v;
        zext = r;
    endfunction : zext

    assign global_pullup_disable = mcu_control_reg[PPOM_BIT_PUD];
    assign global_pullup_disable_out = global_pullup_disable;
    // One write strobe serves every pin of the port.
    assign port_write_strobe = wr_hit(reg_addr_in, PPOM_ADDR_PORT_OUT, reg_write_in);
    assign port_write_strobe_pin = {WIDTH{port_write_strobe}};

    // -------------------------------------------------------------------------
    // Reset seen flag keeps pull-ups off until the first clocked cycle
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reset_seen_reg <= 1'b0;
        end else begin
            reset_seen_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mcu_control_reg <= PPOM_MCU_CONTROL_RST;
        end else if (wr_hit(reg_addr_in, PPOM_ADDR_MCU_CONTROL, reg_write_in)) begin
            mcu_control_reg <= reg_wdata_in & PPOM_MCU_CONTROL_WMASK;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dir_bit_reg <= PPOM_PORT_RST[WIDTH-1:0];
        end else if (wr_hit(reg_addr_in, PPOM_ADDR_PORT_DIR, reg_write_in)) begin
            dir_bit_reg <= reg_wdata_in[WIDTH-1:0];
        end
    end

    // -------------------------------------------------------------------------
    // Output value register: write, software toggle and peripheral toggle
    // -------------------------------------------------------------------------
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_out
            always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    out_value_bit_reg[i] <= PPOM_PORT_RST[i];
                end else if (port_write_strobe_pin[i]) begin
                    out_value_bit_reg[i] <= reg_wdata_in[i];
                end else if (wr_hit(reg_addr_in, PPOM_ADDR_PORT_PIN, reg_write_in) && reg_wdata_in[i]) begin
                    out_value_bit_reg[i] <= ~out_value_bit_reg[i];
                end else if (out_toggle_override_en_in[i]) begin
                    out_value_bit_reg[i] <= ~out_value_bit_reg[i];
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------------
    // Pin cells
    // -------------------------------------------------------------------------
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_pin
            ppom_pin_cell u_cell (
                .dir_bit_in(dir_bit_reg[i]),
                .out_value_bit_in(out_value_bit_reg[i]),
                .global_pullup_disable_in(global_pullup_disable),
                .sleep_clamp_in(sleep_clamp_in),
                .reset_active_in(!reset_seen_reg),
                .ext_int_enabled_in(ext_int_en_reg[i]),
                .pullup_override_en_in(pullup_override_en_in[i]),
                .pullup_override_val_in(pullup_override_val_in[i]),
                .dir_override_en_in(dir_override_en_in[i]),
                .dir_override_val_in(dir_override_val_in[i]),
                .outval_override_en_in(outval_override_en_in[i]),
                .outval_override_val_in(outval_override_val_in[i]),
                .input_en_override_en_in(input_en_override_en_in[i]),
                .input_en_override_val_in(input_en_override_val_in[i]),
                .pad_in(pad_in[i]),
                .pullup_en_out(pullup_en_out[i]),
                .pad_out(pad_out[i]),
                .pad_oe_out(pad_oe_out[i]),
                .schmitt_out(schmitt[i])
            );
        end
    endgenerate

    // Peripherals get the raw Schmitt output and must synchronise it themselves.
    assign alt_digital_in_out = schmitt;
    // The analog pad path is a pad-ring wire outside this logic; nothing here touches it.

    ppom_sync2 #(
        .WIDTH(WIDTH)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .async_in(schmitt),
        .sync_out(pin_input_bit)
    );

    // -------------------------------------------------------------------------
    // External interrupt edge detection
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ext_int_en_reg <= '0;
        end else if (wr_hit(reg_addr_in, PPOM_ADDR_INT_CTRL, reg_write_in)) begin
            ext_int_en_reg <= reg_wdata_in[WIDTH-1:0];
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            int_sense_reg <= '0;
        end else if (wr_hit(reg_addr_in, PPOM_ADDR_INT_SENSE, reg_write_in)) begin
            int_sense_reg[7:0] <= reg_wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prev_in_reg <= '0;
        end else begin
            prev_in_reg <= pin_input_bit;
        end
    end

    // Flags set on edges even while the interrupt is disabled, so a clamp
    // release on a high pin sets the flag on wake.
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            case (ppom_sense_t'(int_sense_reg[2*i +: 2]))
                PPOM_SENSE_ANY: edge_hit[i] = pin_input_bit[i] ^ prev_in_reg[i];
                PPOM_SENSE_FALL: edge_hit[i] = prev_in_reg[i] & ~pin_input_bit[i];
                PPOM_SENSE_RISE: edge_hit[i] = pin_input_bit[i] & ~prev_in_reg[i];
                PPOM_SENSE_LOW: edge_hit[i] = 1'b0;
                default: edge_hit[i] = 1'b0;
            endcase
        end
    end

    // Write one to clear; a simultaneous edge wins over the clear.
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ext_int_flag_reg <= '0;
        end else if (wr_hit(reg_addr_in, PPOM_ADDR_INT_FLAG, reg_write_in)) begin
            ext_int_flag_reg <= (ext_int_flag_reg & ~reg_wdata_in[WIDTH-1:0]) | edge_hit;
        end else begin
            ext_int_flag_reg <= ext_int_flag_reg | edge_hit;
        end
    end
    assign ext_int_flag_out = ext_int_flag_reg;

    // -------------------------------------------------------------------------
    // Read port
    // -------------------------------------------------------------------------
    always_comb begin
        case (reg_addr_in)
            PPOM_ADDR_MCU_CONTROL: rdata_next = mcu_control_reg;
            PPOM_ADDR_PORT_OUT: rdata_next = zext(out_value_bit_reg);
            PPOM_ADDR_PORT_DIR: rdata_next = zext(dir_bit_reg);
            PPOM_ADDR_PORT_PIN: rdata_next = zext(pin_input_bit);
            PPOM_ADDR_INT_CTRL: rdata_next = zext(ext_int_en_reg);
            PPOM_ADDR_INT_FLAG: rdata_next = zext(ext_int_flag_reg);
            PPOM_ADDR_INT_SENSE: rdata_next = int_sense_reg[7:0];
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_read_in) begin
            reg_rdata_out <= rdata_next;
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end
endmodule : ppom_port

// ### sim/ppom_port_props.sv
// Concurrent checks on the ports of the port pin override mux.
`timescale 1ns/10ps
module ppom_port_props
    import ppom_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic sleep_clamp_in,
    input wire logic [WIDTH-1:0] pullup_override_en_in,
    input wire logic [WIDTH-1:0] pullup_override_val_in,
    input wire logic [WIDTH-1:0] dir_override_en_in,
    input wire logic [WIDTH-1:0] dir_override_val_in,
    input wire logic [WIDTH-1:0] outval_override_en_in,
    input wire logic [WIDTH-1:0] outval_override_val_in,
    input wire logic [WIDTH-1:0] out_toggle_override_en_in,
    input wire logic [WIDTH-1:0] input_en_override_en_in,
    input wire logic [WIDTH-1:0] input_en_override_val_in,
    input wire logic [WIDTH-1:0] pad_in,
    input wire logic [WIDTH-1:0] pad_out,
    input wire logic [WIDTH-1:0] pad_oe_out,
    input wire logic [WIDTH-1:0] pullup_en_out,
    input wire logic [WIDTH-1:0] alt_digital_in_out,
    input wire logic global_pullup_disable_out
);
    // ---------------------------------------------------------------------
    // Pull-ups are held off until the first edge after reset, so skip it.
    // ---------------------------------------------------------------------
    logic up_reg;
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            up_reg <= 1'b0;
        end else begin
            up_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    pull_ovr_a: assert property (up_reg |-> ((pullup_en_out ^ pullup_override_val_in) & pullup_override_en_in) == '0)
        else $error("pull-up does not follow its override value");
    pud_off_a: assert property (up_reg && global_pullup_disable_out |-> (pullup_en_out & ~pullup_override_en_in) == '0)
        else $error("pull-up on while globally disabled");
    pud_write_a: assert property (reg_write_in && reg_addr_in == PPOM_ADDR_MCU_CONTROL
        |=> global_pullup_disable_out == $past(reg_wdata_in[PPOM_BIT_PUD])) else $error("pull-up disable bit not stored");
    dir_ovr_a: assert property (((pad_oe_out ^ dir_override_val_in) & dir_override_en_in) == '0)
        else $error("driver enable ignores direction override");
    dir_bit_a: assert property (reg_read_in && reg_addr_in == PPOM_ADDR_PORT_DIR
        |=> ((pad_oe_out ^ reg_rdata_out[WIDTH-1:0]) & ~dir_override_en_in) == '0) else $error("driver enable not dir bit");
    out_val_a: assert property (reg_read_in && reg_addr_in == PPOM_ADDR_PORT_OUT
        |=> ((pad_out ^ reg_rdata_out[WIDTH-1:0]) & pad_oe_out & ~outval_override_en_in) == '0)
        else $error("driven level not the output value bit");
    val_ovr_a: assert property (((pad_out ^ outval_override_val_in) & pad_oe_out & outval_override_en_in) == '0)
        else $error("driven level ignores value override");
    in_ovr_a: assert property (((alt_digital_in_out ^ (pad_in & input_en_override_val_in)) & input_en_override_en_in) == '0)
        else $error("input enable ignores its override");
    in_awake_a: assert property (!sleep_clamp_in |-> ((alt_digital_in_out ^ pad_in) & ~input_en_override_en_in) == '0)
        else $error("digital input not passed straight while awake");
    toggle_a: assert property (out_toggle_override_en_in[0] && pad_oe_out[0] && !reg_write_in && !outval_override_en_in[0]
        ##1 pad_oe_out[0] && !outval_override_en_in[0] |-> pad_out[0] != $past(pad_out[0])) else $error("toggle lost");
    cover property (up_reg && global_pullup_disable_out);
    cover property (out_toggle_override_en_in[0]);
    cover property ($fell(sleep_clamp_in));
endmodule : ppom_port_props

// ### sim/ppom_periph_model.sv
// Behavioural peripheral that owns alternate pin functions and drives the overrides.
`timescale 1ns/10ps
module ppom_periph_model #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic load_in,
    input wire logic [2:0] func_in,
    input wire logic [WIDTH-1:0] en_in,
    input wire logic [WIDTH-1:0] val_in,
    input wire logic [WIDTH-1:0] alt_digital_in_in,
    output logic [WIDTH-1:0] pu_en_out,
    output logic [WIDTH-1:0] pu_val_out,
    output logic [WIDTH-1:0] dir_en_out,
    output logic [WIDTH-1:0] dir_val_out,
    output logic [WIDTH-1:0] ov_en_out,
    output logic [WIDTH-1:0] ov_val_out,
    output logic [WIDTH-1:0] tog_en_out,
    output logic [WIDTH-1:0] ie_en_out,
    output logic [WIDTH-1:0] ie_val_out,
    output logic [WIDTH-1:0] alt_sync_out
);
    logic [WIDTH-1:0] sync1_reg;
    // Each group is loaded per pin; function 7 drops every override at once.
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            {pu_en_out, pu_val_out, dir_en_out, dir_val_out, ov_en_out, ov_val_out} <= '0;
            {tog_en_out, ie_en_out, ie_val_out} <= '0;
        end else begin
            // A toggle request lasts one cycle, since the pin inverts each cycle it is high.
            tog_en_out <= (load_in && func_in == 3'h3) ? en_in : '0;
            if (load_in) begin
                case (func_in)
                    3'h0: {pu_en_out, pu_val_out} <= {en_in, val_in};
                    3'h1: {dir_en_out, dir_val_out} <= {en_in, val_in};
                    3'h2: {ov_en_out, ov_val_out} <= {en_in, val_in};
                    3'h4: {ie_en_out, ie_val_out} <= {en_in, val_in};
                    3'h7: {pu_en_out, dir_en_out, ov_en_out, ie_en_out} <= '0;
                    default: ;
                endcase
            end
        end
    end
    // The consumer synchronises the raw digital input itself.
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            {sync1_reg, alt_sync_out} <= '0;
        end else begin
            {sync1_reg, alt_sync_out} <= {alt_digital_in_in, sync1_reg};
        end
    end
endmodule : ppom_periph_model

// ### sim/ppom_port_tb.sv
// Self-checking bench for the port pin override mux.
`timescale 1ns/10ps
module ppom_port_tb;
    import ppom_pkg::*;
    logic ref_clk_in = 1'b0, arst_n_in = 1'b0, reg_write = 1'b0, reg_read = 1'b0, sleep = 1'b0, load = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, pad_in = 8'h00, en = 8'h00, val = 8'h00, reg_rdata;
    logic [2:0] func = 3'h0;
    logic [7:0] pu_en, pu_val, dir_en, dir_val, ov_en, ov_val, tog_en, ie_en, ie_val, alt_sync;
    logic [7:0] pad_out, pad_oe, pullup_en, alt_in, int_flag;
    logic pud_out;
    int errors = 0;
    int num_checks = 0;
    always #25 ref_clk_in = ~ref_clk_in;
    ppom_port #(.WIDTH(8)) uut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_write_in(reg_write), .reg_read_in(reg_read), .reg_rdata_out(reg_rdata),
        .sleep_clamp_in(sleep), .pullup_override_en_in(pu_en), .pullup_override_val_in(pu_val),
        .dir_override_en_in(dir_en), .dir_override_val_in(dir_val), .outval_override_en_in(ov_en),
        .outval_override_val_in(ov_val), .out_toggle_override_en_in(tog_en), .input_en_override_en_in(ie_en),
        .input_en_override_val_in(ie_val), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe),
        .pullup_en_out(pullup_en), .alt_digital_in_out(alt_in), .ext_int_flag_out(int_flag),
        .global_pullup_disable_out(pud_out));
    ppom_periph_model #(.WIDTH(8)) periph (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .load_in(load),
        .func_in(func), .en_in(en), .val_in(val), .alt_digital_in_in(alt_in), .pu_en_out(pu_en),
        .pu_val_out(pu_val), .dir_en_out(dir_en), .dir_val_out(dir_val), .ov_en_out(ov_en), .ov_val_out(ov_val),
        .tog_en_out(tog_en), .ie_en_out(ie_en), .ie_val_out(ie_val), .alt_sync_out(alt_sync));
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk_in);
        reg_write <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_in);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk_in);
        reg_read <= 1'b0;
        #1;
        check("read data", exp, reg_rdata);
    endtask : rd
    task automatic ovr(input logic [2:0] f, input logic [7:0] e, input logic [7:0] v);
        @(posedge ref_clk_in);
        func <= f;
        en <= e;
        val <= v;
        load <= 1'b1;
        @(posedge ref_clk_in);
        load <= 1'b0;
        #1;
    endtask : ovr
    task automatic env(input logic [7:0] p, input logic s);
        @(posedge ref_clk_in);
        pad_in <= p;
        sleep <= s;
        #1;
    endtask : env
    task automatic test_done;
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    initial begin
        #200000;
        errors++;
        test_done();
    end
    // ---------------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        rd(PPOM_ADDR_MCU_CONTROL, PPOM_MCU_CONTROL_RST);
        rd(8'h7F, 8'h00);
        wr(PPOM_ADDR_MCU_CONTROL, 8'hFF);
        rd(PPOM_ADDR_MCU_CONTROL, PPOM_MCU_CONTROL_WMASK);
        for (int i = 0; i < 8; i++) begin
            wr(PPOM_ADDR_PORT_DIR, {8{i[2]}});
            wr(PPOM_ADDR_PORT_OUT, {8{i[1]}});
            wr(PPOM_ADDR_MCU_CONTROL, {3'h0, i[0], 4'h0});
            check("pullup", {8{i[2:0] == PPOM_PULLUP_PATTERN}}, pullup_en);
            check("pad_oe", {8{i[2]}}, pad_oe);
            check("pad_out", {8{i[2] & i[1]}}, pad_out & pad_oe);
        end
        // Reset in mid-run with pull-ups configured must still hold them off.
        wr(PPOM_ADDR_PORT_DIR, 8'h00);
        wr(PPOM_ADDR_MCU_CONTROL, 8'h00);
        check("pullup on", 8'hFF, pullup_en);
        arst_n_in = 1'b0;
        #1;
        check("pullup in reset", 8'h00, pullup_en);
        repeat (3) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        rd(PPOM_ADDR_PORT_OUT, PPOM_PORT_RST);
        wr(PPOM_ADDR_PORT_OUT, 8'hFF);
        ovr(3'h0, 8'hFF, 8'hA5);
        check("pullup override", 8'hA5, pullup_en);
        wr(PPOM_ADDR_MCU_CONTROL, 8'h10);
        check("pullup override pud", 8'hA5, pullup_en);
        ovr(3'h1, 8'h0F, 8'h05);
        wr(PPOM_ADDR_PORT_DIR, 8'hF0);
        check("dir override", 8'hF5, pad_oe);
        rd(PPOM_ADDR_PORT_DIR, 8'hF0);
        ovr(3'h2, 8'hFF, 8'h3C);
        check("value override", 8'h34, pad_out & pad_oe);
        ovr(3'h7, 8'h00, 8'h00);
        wr(PPOM_ADDR_PORT_OUT, 8'h00);
        wr(PPOM_ADDR_PORT_DIR, 8'h01);
        ovr(3'h3, 8'h01, 8'h00);
        rd(PPOM_ADDR_PORT_OUT, 8'h01);
        wr(PPOM_ADDR_PORT_PIN, 8'h81);
        rd(PPOM_ADDR_PORT_OUT, 8'h80);
        env(8'hFF, 1'b0);
        check("alt awake", 8'hFF, alt_in);
        wr(PPOM_ADDR_INT_CTRL, 8'h02);
        rd(PPOM_ADDR_PORT_PIN, 8'hFF);
        wr(PPOM_ADDR_INT_SENSE, {6'h00, PPOM_SENSE_RISE});
        env(8'hFF, 1'b1);
        ovr(3'h4, 8'h0C, 8'h04);
        check("alt asleep", 8'h06, alt_in);
        repeat (3) @(posedge ref_clk_in);
        #1;
        check("alt synced", 8'h06, alt_sync);
        wr(PPOM_ADDR_INT_FLAG, 8'hFF);
        env(8'hFF, 1'b0);
        repeat (5) @(posedge ref_clk_in);
        #1;
        check("wake flag", 8'h01, int_flag & 8'h01);
        test_done();
    end
endmodule : ppom_port_tb
bind ppom_port ppom_port_props #(.WIDTH(WIDTH)) props (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .sleep_clamp_in(sleep_clamp_in),
    .pullup_override_en_in(pullup_override_en_in), .pullup_override_val_in(pullup_override_val_in),
    .dir_override_en_in(dir_override_en_in), .dir_override_val_in(dir_override_val_in),
    .outval_override_en_in(outval_override_en_in), .outval_override_val_in(outval_override_val_in),
    .out_toggle_override_en_in(out_toggle_override_en_in), .input_en_override_en_in(input_en_override_en_in),
    .input_en_override_val_in(input_en_override_val_in), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_out(pad_oe_out), .pullup_en_out(pullup_en_out), .alt_digital_in_out(alt_digital_in_out),
    .global_pullup_disable_out(global_pullup_disable_out));
